/* File: common/mmgp_pkg.sv */
/*
   Constants, register map and types of the seven-pin multi-mode gpio port.
   Assumes a 50 MHz system clock and an APB master with 32-bit data.
*/
package mmgp_pkg;
   localparam int NPIN = 7;
   localparam int ADDR_W = 8;
   localparam int MODE_W = 2 * NPIN;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_OUT = 8'h04;
   localparam logic [7:0] OFS_IN = 8'h08;
   localparam logic [7:0] OFS_ALARM = 8'h0c;
   localparam logic [7:0] OFS_BUZ = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   typedef enum logic [1:0] {
      MMGP_IN = 2'b00,
      MMGP_OUT = 2'b01,
      MMGP_ALT = 2'b10,
      MMGP_BAD = 2'b11
   } mmgp_mode_t;
   typedef enum logic {
      APB_IDLE = 1'b0,
      APB_DONE = 1'b1
   } mmgp_apb_t;
   // per pin: bit0 input, bit1 output, bit2 alternate; pin6 .. pin0
   localparam logic [3*NPIN-1:0] PIN_CAPS = {3'h7, 3'h7, 3'h3, 3'h3, 3'h3, 3'h2, 3'h1};
   localparam logic [MODE_W-1:0] MODE_RST = 14'h0004;
   localparam logic [NPIN-1:0] OUT_RST = 7'h02;
   localparam int IDX_OC = 1;
   localparam int IDX_ALARM = 5;
   localparam int IDX_BUZ = 6;
   localparam int IRQ_W = 3;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_REJECT = 1;
   localparam int IRQ_INCHG = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
   localparam int ALARM_CLR_BIT = 0;
   localparam int BUZ_HALF_W = 16;
   localparam int BUZ_EN_BIT = 16;
   localparam logic [BUZ_HALF_W:0] BUZ_RST = 17'h00000;
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICK_W = 6;
endpackage

/* File: src/mmgp_sync.sv */
/*
   Three-stage input synchroniser with agreement filter.
   Assumes asynchronous pin levels and one system clock.
*/
`timescale 1ns/1ps
module mmgp_sync #(
   parameter int W = 7
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
      end else begin
         ff1 <= i_async;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_level <= '0;
      end else begin
         o_level <= (ff2 & ~(ff2 ^ ff3)) | (o_level & (ff2 ^ ff3));
      end
   end
endmodule

/* File: src/mmgp_tone.sv */
/*
   Square wave tone generator for the buzzer output.
   Assumes a one-cycle tick enable from the block's divider.
*/
`timescale 1ns/1ps
module mmgp_tone #(
   parameter int HALF_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_en,
   input wire logic [HALF_W-1:0] i_half,
   output logic o_wave
);
   logic [HALF_W-1:0] cnt;
   logic [HALF_W-1:0] last;

   // a half period of zero is taken as one tick
   assign last = (i_half == '0) ? '0 : i_half - 1'b1;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= '0;
         o_wave <= 1'b0;
      end else if (!i_en) begin
         cnt <= '0;
         o_wave <= 1'b0;
      end else if (i_tick) begin
         if (cnt >= last) begin
            cnt <= '0;
            o_wave <= ~o_wave;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule

/* File: src/mmgp_top.sv */
/*
   Seven-pin multi-mode gpio port with APB register access, alarm latch,
   buzzer tone output and a level interrupt.
   Assumes an APB master on i_sys_clk and asynchronous pin inputs.
*/
`timescale 1ns/1ps
module mmgp_top
   import mmgp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic [NPIN-1:0] i_pin_in,
   output logic [NPIN-1:0] o_pin_out,
   output logic [NPIN-1:0] o_pin_oe,
   input wire logic i_alarm_start,
   output logic o_irq
);

   mmgp_apb_t apb_state;
   logic [MODE_W-1:0] mode;
   logic [NPIN-1:0] out_lvl;
   logic [NPIN-1:0] pin_lvl;
   logic [NPIN-1:0] pin_lvl_d;
   logic alarm;
   logic [BUZ_HALF_W:0] buz;
   logic buz_wave;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_set;
   logic [TICK_W-1:0] tick_cnt;
   logic tick;
   logic commit;
   logic wr_mode;
   logic wr_out;
   logic wr_alarm;
   logic wr_buz;
   logic wr_stat;
   logic wr_mask;
   logic reject;
   logic [NPIN-1:0] in_mask;
   logic [31:0] next_prdata;
   logic next_pslverr;

   // whether a pin offers a mode
   function automatic logic mode_ok(input int pin, input logic [1:0] m);
      logic [2:0] caps;
      caps = PIN_CAPS[3*pin +: 3];
      case (m)
         MMGP_IN: mode_ok = caps[0];
         MMGP_OUT: mode_ok = caps[1];
         MMGP_ALT: mode_ok = caps[2];
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // whether an address is mapped
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_MODE, OFS_OUT, OFS_IN, OFS_ALARM, OFS_BUZ, OFS_IRQ_STAT, OFS_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   endfunction

   // apb: one wait cycle, answer registered
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         apb_state <= APB_IDLE;
      end else begin
         case (apb_state)
            APB_IDLE: begin
               if (i_psel && i_penable) begin
                  apb_state <= APB_DONE;
               end
            end
            APB_DONE: begin
               apb_state <= APB_IDLE;
            end
            default: begin
               apb_state <= APB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else if (apb_state == APB_IDLE && i_psel && i_penable) begin
         o_pready <= 1'b1;
         o_prdata <= i_pwrite ? 32'h00000000 : next_prdata;
         o_pslverr <= next_pslverr;
      end else begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
      end
   end

   assign commit = (apb_state == APB_DONE) && i_psel && i_penable && i_pwrite && addr_ok(i_paddr);
   assign wr_mode = commit && (i_paddr == OFS_MODE);
   assign wr_out = commit && (i_paddr == OFS_OUT);
   assign wr_alarm = commit && (i_paddr == OFS_ALARM);
   assign wr_buz = commit && (i_paddr == OFS_BUZ);
   assign wr_stat = commit && (i_paddr == OFS_IRQ_STAT);
   assign wr_mask = commit && (i_paddr == OFS_IRQ_MASK);

   // read mux
   always_comb begin
      next_prdata = 32'h00000000;
      next_pslverr = !addr_ok(i_paddr);
      case (i_paddr)
         OFS_MODE: next_prdata[MODE_W-1:0] = mode;
         OFS_OUT: next_prdata[NPIN-1:0] = out_lvl;
         OFS_IN: next_prdata[NPIN-1:0] = pin_lvl & in_mask;
         OFS_ALARM: next_prdata[ALARM_CLR_BIT] = alarm;
         OFS_BUZ: next_prdata[BUZ_HALF_W:0] = buz;
         OFS_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
         OFS_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
         default: next_prdata = 32'h00000000;
      endcase
   end

   // pins currently in input mode
   always_comb begin
      in_mask = '0;
      for (int i = 0; i < NPIN; i++) begin
         in_mask[i] = (mode[2*i +: 2] == MMGP_IN);
      end
   end

   // mode request check
   always_comb begin
      reject = 1'b0;
      for (int i = 0; i < NPIN; i++) begin
         if (!mode_ok(i, i_pwdata[2*i +: 2])) begin
            reject = wr_mode;
         end
      end
   end

   // mode register, per-pin acceptance
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode <= MODE_RST;
      end else if (wr_mode) begin
         for (int i = 0; i < NPIN; i++) begin
            if (mode_ok(i, i_pwdata[2*i +: 2])) begin
               mode[2*i +: 2] <= i_pwdata[2*i +: 2];
            end
         end
      end
   end

   // output level register
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_lvl <= OUT_RST;
      end else if (wr_out) begin
         out_lvl <= i_pwdata[NPIN-1:0];
      end
   end

   // alarm latch: start wins over the clearing command
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm <= 1'b0;
      end else if (i_alarm_start) begin
         alarm <= 1'b1;
      end else if (wr_alarm && i_pwdata[ALARM_CLR_BIT]) begin
         alarm <= 1'b0;
      end
   end

   // buzzer control
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buz <= BUZ_RST;
      end else if (wr_buz) begin
         buz <= i_pwdata[BUZ_HALF_W:0];
      end
   end

   // tick divider
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   mmgp_tone #(
      .HALF_W(BUZ_HALF_W)
   ) u_tone (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_tick(tick),
      .i_en(buz[BUZ_EN_BIT] && (mode[2*IDX_BUZ +: 2] == MMGP_ALT)),
      .i_half(buz[BUZ_HALF_W-1:0]),
      .o_wave(buz_wave)
   );

   mmgp_sync #(
      .W(NPIN)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_pin_in),
      .o_level(pin_lvl)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_lvl_d <= '0;
      end else begin
         pin_lvl_d <= pin_lvl;
      end
   end

   // pin drivers
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pin_out <= '0;
         o_pin_oe <= '0;
      end else begin
         for (int i = 0; i < NPIN; i++) begin
            case (mode[2*i +: 2])
               MMGP_OUT: begin
                  if (i == IDX_OC) begin
                     o_pin_out[i] <= 1'b0;
                     o_pin_oe[i] <= ~out_lvl[i];
                  end else begin
                     o_pin_out[i] <= out_lvl[i];
                     o_pin_oe[i] <= 1'b1;
                  end
               end
               MMGP_ALT: begin
                  o_pin_oe[i] <= 1'b1;
                  if (i == IDX_ALARM) begin
                     o_pin_out[i] <= alarm;
                  end else if (i == IDX_BUZ) begin
                     o_pin_out[i] <= buz_wave;
                  end else begin
                     o_pin_out[i] <= 1'b0;
                  end
               end
               default: begin
                  o_pin_out[i] <= 1'b0;
                  o_pin_oe[i] <= 1'b0;
               end
            endcase
         end
      end
   end

   // interrupt events
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_ALARM] = i_alarm_start;
      irq_set[IRQ_REJECT] = reject;
      irq_set[IRQ_INCHG] = |((pin_lvl ^ pin_lvl_d) & in_mask);
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat <= IRQ_RST;
      end else if (wr_stat) begin
         irq_stat <= (irq_stat & ~i_pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat <= irq_stat | irq_set;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_mask <= IRQ_RST;
      end else if (wr_mask) begin
         irq_mask <= i_pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask);
      end
   end
endmodule

/* File: verif/mmgp_ext_model.sv */
/* Far side of the port: outside drivers and the pull-up on the open collector pin.
   Assumes the bench sets what outside devices drive on undriven pins. */
`timescale 1ns/1ps
module mmgp_ext_model
   import mmgp_pkg::*;
(
   input wire logic [NPIN-1:0] i_pin_out,
   input wire logic [NPIN-1:0] i_pin_oe,
   input wire logic [NPIN-1:0] i_ext,
   output logic [NPIN-1:0] o_wire
);
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         o_wire[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext[i];
      end
      if (!i_pin_oe[IDX_OC]) begin
         o_wire[IDX_OC] = 1'b1;
      end
   end
endmodule

/* File: verif/mmgp_assertions.sv */
/* Port checker of the gpio block, bound below.
   Assumes one clock and the top module's ports only. */
`timescale 1ns/1ps
module mmgp_assertions
   import mmgp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic [NPIN-1:0] o_pin_out,
   input wire logic [NPIN-1:0] o_pin_oe,
   input wire logic i_alarm_start
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_access;
      i_psel && $rose(i_penable);
   endsequence
   sequence s_pulse;
      o_pready ##1 !o_pready;
   endsequence
   AST_ANSWER: assert property (s_access |=> s_pulse)
      else $error("no single ready pulse after access");
   AST_IDLE_ZERO: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside ready");
   AST_ERR: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("bad error response");
   AST_IN_ONLY: assert property (!o_pin_oe[0])
      else $error("input only pin driven");
   AST_OC: assert property (!o_pin_out[IDX_OC])
      else $error("open collector pin driven high");
   AST_ALARM_FALL: assert property ($fell(o_pin_out[IDX_ALARM]) |-> $past(o_pready && i_pwrite, 2))
      else $error("alarm pin fell without host write");
   AST_ALARM_RISE: assert property ($rose(o_pin_out[IDX_ALARM]) |->
      $past(i_alarm_start, 2) || $past(o_pready && i_pwrite, 2))
      else $error("alarm pin rose without cause");
   AST_OE_BY_WRITE: assert property ($changed(o_pin_oe[4:0]) |-> $past(o_pready && i_pwrite, 2))
      else $error("pin drive changed without write");
endmodule
bind mmgp_top mmgp_assertions u_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .i_pwrite(i_pwrite),
   .o_pready(o_pready),
   .o_prdata(o_prdata),
   .o_pslverr(o_pslverr),
   .o_pin_out(o_pin_out),
   .o_pin_oe(o_pin_oe),
   .i_alarm_start(i_alarm_start)
);

/* File: verif/multi_mode_gpio_port_tb_top.sv */
/* Self-checking bench of the gpio block with a mode model.
   Assumes the outside model and the bound checker. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module multi_mode_gpio_port_tb_top
   import mmgp_pkg::*;
;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, alarm = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, prdata;
   logic pready, pslverr, irq;
   logic [NPIN-1:0] pin_w, pin_out, pin_oe, ext = '0, outr = 7'h02;
   logic [15:0] seed = 16'h0011;
   int n_mismatch = 0, n_compared = 0, md[NPIN], cap[NPIN] = '{1, 2, 3, 3, 3, 7, 7};
   always #10 sys_clk = ~sys_clk;
   mmgp_top dut (
      .i_sys_clk(sys_clk),
      .i_rst_n(rst_n),
      .i_psel(psel),
      .i_penable(penable),
      .i_pwrite(pwrite),
      .i_paddr(paddr),
      .i_pwdata(pwdata),
      .o_pready(pready),
      .o_prdata(prdata),
      .o_pslverr(pslverr),
      .i_pin_in(pin_w),
      .o_pin_out(pin_out),
      .o_pin_oe(pin_oe),
      .i_alarm_start(alarm),
      .o_irq(irq)
   );
   mmgp_ext_model u_ext (
      .i_pin_out(pin_out),
      .i_pin_oe(pin_oe),
      .i_ext(ext),
      .o_wire(pin_w)
   );
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] mword();
      mword = '0;
      for (int i = 0; i < NPIN; i++) mword[2*i +: 2] = 2'(md[i]);
   endfunction
   task automatic test_done;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // ready, read data and error are taken at the completing rising edge
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         test_done();
      end
      rd = prdata;
      `CHK("pslverr", a > OFS_IRQ_MASK, pslverr)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pins;
      logic [NPIN-1:0] e;
      e = '0;
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < NPIN; i++) begin
         if (md[i] == 1) begin
            `CHK("oe", (i == 1) ? !outr[1] : 1'b1, pin_oe[i])
            `CHK("out", (i == 1) ? 1'b0 : outr[i], pin_out[i])
         end
         if (md[i] == 0) begin
            `CHK("oe in", 1'b0, pin_oe[i])
            e[i] = ext[i];
         end
      end
      apb(1'b0, OFS_IN, 32'h0);
      `CHK("in", {25'h0, e}, rd)
   endtask
   initial begin
      int t, c;
      logic v;
      foreach (md[i]) md[i] = (i == 1);
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_MODE, 32'h0);
      `CHK("mode rst", 32'h4, rd)
      `CHK("oe rst", 7'h0, pin_oe)
      pins();
      apb(1'b0, 8'h1c, 32'h0);
      for (int p = 0; p < NPIN; p++) begin
         for (int m = 0; m < 4; m++) begin
            logic [31:0] w;
            w = mword();
            w[2*p +: 2] = 2'(m);
            apb(1'b1, OFS_MODE, w);
            if (m < 3 && cap[p][m]) md[p] = m;
            apb(1'b0, OFS_MODE, 32'h0);
            `CHK("mode", mword(), rd)
            apb(1'b0, OFS_IRQ_STAT, 32'h0);
            `CHK("reject", !(m < 3 && cap[p][m]), rd[IRQ_REJECT])
            apb(1'b1, OFS_IRQ_STAT, 32'h2);
         end
      end
      for (int r = 0; r < 6; r++) begin
         foreach (md[i]) if (i > 1) md[i] = r % 2;
         seed = lfsr(seed);
         ext <= seed[13:7];
         outr = seed[6:0];
         apb(1'b1, OFS_MODE, mword());
         apb(1'b1, OFS_OUT, {25'h0, outr});
         pins();
      end
      // level change on the input-only pin sets the change flag
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      ext <= ~ext;
      repeat (8) @(negedge sys_clk);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      `CHK("inchg", 1'b1, rd[IRQ_INCHG])
      md[5] = 2;
      md[6] = 2;
      apb(1'b1, OFS_MODE, mword());
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      alarm <= 1'b1;
      @(posedge sys_clk);
      alarm <= 1'b0;
      apb(1'b1, OFS_OUT, 32'h0);
      `CHK("alarm pin", 1'b1, pin_out[5])
      `CHK("irq", 1'b1, irq)
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      repeat (2) @(negedge sys_clk);
      `CHK("irq mask", 1'b0, irq)
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(negedge sys_clk);
      `CHK("irq clr", 1'b0, irq)
      apb(1'b0, OFS_ALARM, 32'h0);
      `CHK("latch", 32'h1, rd)
      apb(1'b1, OFS_ALARM, 32'h1);
      repeat (2) @(negedge sys_clk);
      `CHK("alarm off", 1'b0, pin_out[5])
      apb(1'b1, OFS_BUZ, 32'h10002);
      v = pin_out[6];
      t = 0;
      c = 0;
      for (int n = 0; n < 1000 && t < 3; n++) begin
         @(negedge sys_clk);
         c++;
         if (pin_out[6] !== v) begin
            v = pin_out[6];
            t++;
            if (t == 3) `CHK("half", 2 * TICK_CYC, c)
            c = 0;
         end
      end
      if (t < 3) n_mismatch++;
      test_done();
   end
endmodule
